// ---- matrix_arb_defs.vh ----
// constants for the multi-layer slave arbiter
// assumes an APB register port and AHB-Lite master request buses
// Summary of operation
// - each master decodes with its own remap
// - boot area routes to ROM or flash
// - no-default policy disconnects slave when idle
// - last-access policy parks on latest requester
// - fixed policy parks on software-chosen master
// - 2-bit kind, 4-bit fixed master selector
// - one independent arbiter per slave
// - per-slave round-robin or fixed-priority select
// - parking policy combines with either algorithm
// - rearbitrate only at idle, single, end, slot
// - idle means unconnected or owner not accessing
// - defined burst ends at its own length
// - undefined INCR unbroken or split at boundary
// - split code 0 none,1 single,2-4 4/8/16
// - slot counter loads at burst start, decrements
// - expired slot allows rearbitration after transfer
// - round-robin serves lowest first, then rotates
// - unparked round-robin grant costs one cycle
// - last master zero latency, others one
// - fixed master zero latency, others one
// - fixed priority grants largest priority value
// - equal priority goes to highest master number
// - per-slave programmable priority for each master
// - connect costs one cycle, parked master none
`ifndef MATRIX_ARB_DEFS_VH
`define MATRIX_ARB_DEFS_VH

`define NM 6
`define NS 9

// register offsets
`define MCFG_BASE 12'h000
`define SCFG_BASE 12'h040
`define PRAS_BASE 12'h080
`define PRAS_STEP 8
`define MRCR_OFF 12'h100
`define STAT_OFF 12'h120

// slave setup fields and reset values
`define SLOT_LSB 0
`define DTYPE_LSB 16
`define FIXM_LSB 18
`define ARBITRATION_KIND_SEL_LSB 24
`define SCFG_RST 32'h00000010
`define SCFG0_RST 32'h00010010
`define SCFG1_RST 32'h00050010

`define DEF_NONE 2'h0
`define DEF_LAST 2'h1
`define DEF_FIXED 2'h2
`define ARB_FIX 2'h1

// address decode
`define BOOT_TOP 8'h00
`define SLV_TOP 4'h1
`define ROM_SLV 4'h2
`define FLASH_SLV 4'h3
`define NO_SLV 4'hF

`endif

// ---- multilayer_slave_arbiter.v ----
// per-slave arbitration and grant logic of a multi-layer AHB-Lite matrix
// assumes master request buses and slave ready come from the same clock
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "matrix_arb_defs.vh"

module multilayer_slave_arbiter (
  input wire i_clk, // system clock
  input wire i_srst, // sync reset, active high
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb write
  input wire [11:0] i_paddr, // apb byte address
  input wire [31:0] i_pwdata, // apb write data
  output wire [31:0] o_prdata, // apb read data
  output wire o_pready, // apb ready
  output wire o_pslverr, // apb error
  input wire [2*`NM-1:0] i_m_htrans, // htrans per master
  input wire [3*`NM-1:0] i_m_hburst, // hburst per master
  input wire [32*`NM-1:0] i_m_haddr, // haddr per master
  input wire [`NS-1:0] i_s_hready, // hready per slave
  output wire [`NS*`NM-1:0] o_grant // grant, slave s bit s*6+m
);

  // ==========================================================
  // apb access timing
  reg rdy;
  reg err;
  reg [31:0] rdata;
  reg [31:0] next_rdata;
  reg next_err;
  wire wr_en;
  wire setup;

  assign setup = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & rdy & i_pwrite;
  assign o_prdata = rdata;
  assign o_pready = rdy;
  assign o_pslverr = err;

  // ==========================================================
  // master side: remap, split setting, decoder
  reg [`NM-1:0] remap;
  wire [3*`NM-1:0] undefined_burst_split_f;
  wire [`NS*`NM-1:0] req;
  wire [`NS-1:0] busy;

  always @(posedge i_clk) begin
    if (i_srst) begin
      remap <= 6'h00;
    end else if (wr_en && i_paddr == `MRCR_OFF) begin
      remap <= i_pwdata[5:0];
    end
  end

  genvar m, n;
  generate
    for (m = 0; m < `NM; m = m + 1) begin : g_m
      reg [2:0] undefined_burst_split;
      reg [3:0] dsel;
      wire [31:0] ha = i_m_haddr[32*m +: 32];

      always @(posedge i_clk) begin
        if (i_srst) begin
          undefined_burst_split <= 3'h0;
        end else if (wr_en && i_paddr == `MCFG_BASE + 4*m) begin
          undefined_burst_split <= i_pwdata[2:0];
        end
      end
      assign undefined_burst_split_f[3*m +: 3] = undefined_burst_split;

      // boot area follows this master's own remap bit
      always @* begin
        if (ha[31:24] == `BOOT_TOP) begin
          dsel = remap[m] ? `FLASH_SLV : `ROM_SLV;
        end else if (ha[31:28] == `SLV_TOP && ha[27:24] < `NS) begin
          dsel = ha[27:24];
        end else begin
          dsel = `NO_SLV;
        end
      end

      for (n = 0; n < `NS; n = n + 1) begin : g_r
        assign req[n*`NM+m] = i_m_htrans[2*m+1] && dsel == n;
      end
    end
  endgenerate

  // ==========================================================
  // slave side: setup registers and one arbiter each
  wire [32*`NS-1:0] scfg_rd;
  wire [32*`NS-1:0] pras_rd;

  genvar s;
  generate
    for (s = 0; s < `NS; s = s + 1) begin : g_s
      localparam [31:0] RV = (s == 0) ? `SCFG0_RST :
                             (s == 1) ? `SCFG1_RST : `SCFG_RST;
      reg [7:0] slot;
      reg [1:0] dtype;
      reg [3:0] fixm;
      reg [1:0] arbitration_kind_sel;
      reg [11:0] prio;
      reg [2:0] own;
      reg own_v;
      reg [2:0] rr;
      reg lastv;
      reg [4:0] cnt;
      reg [7:0] slc;
      reg [5:0] gnt;
      reg [2:0] next_own;
      reg next_v;
      reg [2:0] win;
      reg [1:0] best;
      reg found;
      reg [4:0] blen;
      reg [4:0] ulen;
      reg [4:0] eff;
      reg [4:0] next_cnt;
      integer i;
      integer j;
      wire [5:0] rq = req[s*`NM +: `NM];
      wire [1:0] otr = i_m_htrans[own*2 +: 2];
      wire [2:0] obu = i_m_hburst[own*3 +: 3];
      wire [2:0] oul = undefined_burst_split_f[own*3 +: 3];
      wire nonseq = otr == 2'h2;
      wire idle = !own_v || !rq[own];
      wire acc = !idle && i_s_hready[s];
      wire slexp = acc && !nonseq && slc == 8'h00;
      wire arb = idle || (acc && eff == 5'd1) || slexp;

      // ------------------------------------------------------
      // setup registers
      always @(posedge i_clk) begin
        if (i_srst) begin
          slot <= RV[`SLOT_LSB +: 8];
          dtype <= RV[`DTYPE_LSB +: 2];
          fixm <= RV[`FIXM_LSB +: 4];
          arbitration_kind_sel <= RV[`ARBITRATION_KIND_SEL_LSB +: 2];
          prio <= 12'h000;
        end else begin
          if (wr_en && i_paddr == `SCFG_BASE + 4*s) begin
            slot <= i_pwdata[`SLOT_LSB +: 8];
            dtype <= i_pwdata[`DTYPE_LSB +: 2];
            fixm <= i_pwdata[`FIXM_LSB +: 4];
            arbitration_kind_sel <= i_pwdata[`ARBITRATION_KIND_SEL_LSB +: 2];
          end
          if (wr_en && i_paddr == `PRAS_BASE + `PRAS_STEP*s) begin
            prio <= {i_pwdata[21:20], i_pwdata[17:16], i_pwdata[13:12],
                     i_pwdata[9:8], i_pwdata[5:4], i_pwdata[1:0]};
          end
        end
      end
      assign scfg_rd[32*s +: 32] = {6'h00, arbitration_kind_sel, 2'h0, fixm, dtype, 8'h00, slot};
      assign pras_rd[32*s +: 32] = {8'h00, 2'h0, prio[11:10], 2'h0, prio[9:8],
                                    2'h0, prio[7:6], 2'h0, prio[5:4],
                                    2'h0, prio[3:2], 2'h0, prio[1:0]};
      assign busy[s] = own_v;
      assign o_grant[s*`NM +: `NM] = gnt;

      // ------------------------------------------------------
      // predicted end of burst for the connected master
      always @* begin
        case (oul)
          3'h1: ulen = 5'd1;
          3'h2: ulen = 5'd4;
          3'h3: ulen = 5'd8;
          3'h4: ulen = 5'd16;
          default: ulen = 5'd0;
        endcase
        case (obu)
          3'h0: blen = 5'd1;
          3'h1: blen = ulen;
          3'h2, 3'h3: blen = 5'd4;
          3'h4, 3'h5: blen = 5'd8;
          default: blen = 5'd16;
        endcase
        eff = nonseq ? blen : cnt;
        // split counts reload at each boundary; zero means never ends
        if (eff == 5'd0) begin
          next_cnt = 5'd0;
        end else if (eff == 5'd1) begin
          next_cnt = (obu == 3'h1) ? ulen : 5'd0;
        end else begin
          next_cnt = eff - 5'd1;
        end
      end

      // ------------------------------------------------------
      // winner selection
      always @* begin
        win = 3'h0;
        best = 2'h0;
        found = 1'b0;
        j = 0;
        if (arbitration_kind_sel == `ARB_FIX) begin
          // >= lets a later, higher-numbered master take a tie
          for (i = 0; i < `NM; i = i + 1) begin
            if (rq[i] && (!found || prio[2*i +: 2] >= best)) begin
              win = i[2:0];
              best = prio[2*i +: 2];
              found = 1'b1;
            end
          end
        end else begin
          // pointer starts at the top so master 0 wins first
          for (i = 1; i <= `NM; i = i + 1) begin
            j = (rr + i) % `NM;
            if (rq[j] && !found) begin
              win = j[2:0];
              found = 1'b1;
            end
          end
        end
      end

      // ------------------------------------------------------
      // next connection
      always @* begin
        next_own = own;
        next_v = own_v;
        if (arb) begin
          if (found) begin
            next_own = win;
            next_v = 1'b1;
          end else begin
            case (dtype)
              `DEF_LAST: begin
                next_own = rr;
                next_v = lastv;
              end
              `DEF_FIXED: begin
                next_own = fixm[2:0];
                next_v = fixm < `NM;
              end
              default: begin
                next_v = 1'b0;
              end
            endcase
          end
        end
      end

      // ------------------------------------------------------
      // grant and counters; a new connection shows next cycle
      always @(posedge i_clk) begin
        if (i_srst) begin
          own <= 3'h0;
          own_v <= 1'b0;
          rr <= 3'h5;
          lastv <= 1'b0;
          cnt <= 5'd0;
          slc <= 8'h00;
          gnt <= 6'h00;
        end else begin
          own <= next_own;
          own_v <= next_v;
          gnt <= next_v ? (6'h01 << next_own) : 6'h00;
          if (arb && found) begin
            rr <= win;
            lastv <= 1'b1;
          end
          if (acc) begin
            cnt <= next_cnt;
          end
          if ((acc && nonseq) || (arb && found)) begin
            slc <= slot;
          end else if (slc != 8'h00) begin
            slc <= slc - 8'h01;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // apb read mux and answer
  integer k;

  always @* begin
    next_rdata = 32'h00000000;
    next_err = 1'b1;
    if (i_paddr == `MRCR_OFF) begin
      next_rdata = {26'h0000000, remap};
      next_err = 1'b0;
    end
    if (i_paddr == `STAT_OFF) begin
      next_rdata = {23'h000000, busy};
      next_err = 1'b0;
    end
    for (k = 0; k < `NM; k = k + 1) begin
      if (i_paddr == `MCFG_BASE + 4*k) begin
        next_rdata = {29'h00000000, undefined_burst_split_f[3*k +: 3]};
        next_err = 1'b0;
      end
    end
    for (k = 0; k < `NS; k = k + 1) begin
      if (i_paddr == `SCFG_BASE + 4*k) begin
        next_rdata = scfg_rd[32*k +: 32];
        next_err = 1'b0;
      end
      if (i_paddr == `PRAS_BASE + `PRAS_STEP*k) begin
        next_rdata = pras_rd[32*k +: 32];
        next_err = 1'b0;
      end
    end
  end

  // one wait-free access cycle: answer is set up during setup phase
  always @(posedge i_clk) begin
    if (i_srst) begin
      rdy <= 1'b0;
      err <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      rdy <= setup;
      if (setup) begin
        err <= next_err;
        rdata <= i_pwrite ? 32'h00000000 : next_rdata;
      end else begin
        err <= 1'b0;
      end
    end
  end

endmodule

// ---- msa_props.sv ----
// assertions on the slave arbiter ports
// assumes slave 0 keeps last-access parking and slave 4 keeps no parking
`timescale 1ns/1ps
`include "matrix_arb_defs.vh"
module msa_props (
  input wire i_clk, // clock
  input wire i_srst, // sync reset
  input wire i_psel, // apb select
  input wire i_penable, // apb enable
  input wire i_pwrite, // apb write
  input wire [11:0] i_paddr, // apb address
  input wire [31:0] i_pwdata, // apb write data
  input wire [31:0] o_prdata, // apb read data
  input wire o_pready, // apb ready
  input wire o_pslverr, // apb error
  input wire [2*`NM-1:0] i_m_htrans, // htrans
  input wire [3*`NM-1:0] i_m_hburst, // hburst
  input wire [32*`NM-1:0] i_m_haddr, // haddr
  input wire [`NS-1:0] i_s_hready, // hready
  input wire [`NS*`NM-1:0] o_grant // grants
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ==========
  // requesting masters for one address top byte
  function automatic logic [5:0] reqs(input logic [7:0] top);
    for (int m = 0; m < 6; m++) begin
      reqs[m] = i_m_htrans[2*m+1] && (i_m_haddr[32*m+24 +: 8] == top);
    end
  endfunction
  // ==========
  // register port
  a_pready_next: assert property (i_psel && !i_penable |=> o_pready)
    else $error("ready missing after setup");
  a_pready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  a_error_zero: assert property (o_pslverr |-> o_pready && o_prdata == 32'h00000000)
    else $error("error without ready or with data");
  // ==========
  // grants
  for (genvar s = 0; s < `NS; s++) begin : g_oh
    a_grant_onehot: assert property ($onehot0(o_grant[6*s +: 6]))
      else $error("more than one master on a slave");
  end
  a_burst_hold: assert property (o_grant[41:36] != 6'h00 && !i_s_hready[6] &&
    (reqs(8'h16) & o_grant[41:36]) != 6'h00 |=> $stable(o_grant[41:36]))
    else $error("grant moved inside a transfer");
  a_idle_drop: assert property (reqs(8'h14) == 6'h00 |=> o_grant[29:24] == 6'h00)
    else $error("unparked slave still connected");
  a_connect_lat: assert property (o_grant[29:24] == 6'h00 && reqs(8'h14) != 6'h00
    |=> $onehot(o_grant[29:24]))
    else $error("connect took more than one cycle");
  a_last_park: assert property (reqs(8'h10) == 6'h00 && o_grant[5:0] != 6'h00
    |=> $stable(o_grant[5:0]))
    else $error("last master not kept");
endmodule
bind multilayer_slave_arbiter msa_props i_msa_props (.i_clk(i_clk), .i_srst(i_srst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_m_htrans(i_m_htrans), .i_m_hburst(i_m_hburst), .i_m_haddr(i_m_haddr),
  .i_s_hready(i_s_hready), .o_grant(o_grant));

// ---- ahb_master_model.sv ----
// six AHB-Lite masters issuing NONSEQ or SEQ beats while asked to
// assumes the bench changes requests right after a rising edge
`timescale 1ns/1ps
module ahb_master_model (
  input wire [5:0] i_req, // request per master
  input wire [47:0] i_tgt, // address top byte per master
  input wire [2:0] i_burst, // burst code for all
  input wire [5:0] i_seq, // sequential beat per master
  output logic [11:0] o_htrans, // htrans per master
  output logic [17:0] o_hburst, // hburst per master
  output logic [191:0] o_haddr // haddr per master
);
  always @* begin
    for (int m = 0; m < 6; m++) begin
      o_htrans[2*m +: 2] = i_req[m] ? (i_seq[m] ? 2'h3 : 2'h2) : 2'h0;
      o_hburst[3*m +: 3] = i_burst;
      // idle address inverted so a stale target never looks live
      o_haddr[32*m +: 32] = {i_req[m] ? i_tgt[8*m +: 8] : ~i_tgt[8*m +: 8], 24'h000000};
    end
  end
endmodule

// ---- multilayer_slave_arbiter_bench.sv ----
// self-checking bench for the slave arbiter
// assumes one clock, APB register port and the master model
`timescale 1ns/1ps
`include "matrix_arb_defs.vh"
module multilayer_slave_arbiter_bench;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [5:0] req = 6'h00;
  logic [5:0] seq = 6'h00;
  logic [2:0] burst = 3'h0;
  logic [47:0] tgt = 48'h000000000000;
  logic [8:0] hready = 9'h1FF;
  logic [11:0] htrans;
  logic [17:0] hburst;
  logic [191:0] haddr;
  logic [53:0] grant;
  int fail_count = 0, n_tests = 0;
  always #5 i_clk = ~i_clk;
  ahb_master_model i_ahb_master_model (.i_req(req), .i_tgt(tgt), .i_burst(burst), .i_seq(seq),
    .o_htrans(htrans), .o_hburst(hburst), .o_haddr(haddr));
  multilayer_slave_arbiter i_multilayer_slave_arbiter (.i_clk(i_clk), .i_srst(i_srst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_m_htrans(htrans), .i_m_hburst(hburst), .i_m_haddr(haddr), .i_s_hready(hready),
    .o_grant(grant));
  // ==========
  // helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] gs(input int s);
    return {26'h0, grant[6*s +: 6]};
  endfunction
  // reads before the edge's updates land, so sees the prior cycle
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========
  // scenarios
  task t_regs;
    apb(1'b0, `SCFG_BASE, 32'h0);
    chk(rd, `SCFG0_RST);
    apb(1'b0, `SCFG_BASE + 12'h004, 32'h0);
    chk(rd, `SCFG1_RST);
    apb(1'b0, `SCFG_BASE + 12'h010, 32'h0);
    chk(rd, `SCFG_RST);
    apb(1'b1, `PRAS_BASE + 12'h030, 32'h00030030);
    apb(1'b0, `PRAS_BASE + 12'h030, 32'h0);
    chk(rd, 32'h00030030);
    apb(1'b0, 12'h018, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, `MCFG_BASE + 12'h004, 32'h00000002);
    apb(1'b0, `MCFG_BASE + 12'h004, 32'h0);
    chk(rd, 32'h00000002);
  endtask
  task t_rr;
    tgt <= 48'h141414141414;
    req <= 6'h03;
    cyc(1);
    chk(gs(4), 32'h0);
    cyc(1);
    chk(gs(4), 32'h1);
    cyc(3);
    chk(gs(4), 32'h2);
    req <= 6'h00;
    cyc(3);
    chk(gs(4), 32'h0);
  endtask
  task t_last;
    tgt <= 48'h101010101010;
    req <= 6'h04;
    cyc(3);
    req <= 6'h00;
    cyc(3);
    chk(gs(0), 32'h4);
    req <= 6'h08;
    cyc(1);
    chk(gs(0), 32'h4);
    cyc(1);
    chk(gs(0), 32'h8);
    req <= 6'h00;
  endtask
  task t_fixed;
    apb(1'b1, `SCFG_BASE + 12'h014, 32'h000E0010);
    cyc(3);
    chk(gs(5), 32'h8);
    tgt <= 48'h151515151515;
    req <= 6'h01;
    cyc(1);
    chk(gs(5), 32'h8);
    cyc(1);
    chk(gs(5), 32'h1);
    req <= 6'h00;
    cyc(3);
    chk(gs(5), 32'h8);
  endtask
  task t_prio;
    // master 1 above master 4 first, then both equal
    apb(1'b1, `PRAS_BASE + 12'h030, 32'h00000030);
    apb(1'b1, `SCFG_BASE + 12'h018, 32'h01000010);
    tgt <= 48'h161616161616;
    hready <= 9'h0BF;
    req <= 6'h12;
    cyc(2);
    chk(gs(6), 32'h2);
    cyc(4);
    chk(gs(6), 32'h2);
    req <= 6'h00;
    hready <= 9'h1FF;
    apb(1'b1, `PRAS_BASE + 12'h030, 32'h0);
    req <= 6'h12;
    cyc(2);
    chk(gs(6), 32'h10);
    req <= 6'h00;
    cyc(1);
  endtask
  task t_remap;
    tgt <= 48'h000000000000;
    req <= 6'h01;
    cyc(2);
    chk(gs(2), 32'h1);
    req <= 6'h00;
    apb(1'b1, `MRCR_OFF, 32'h1);
    req <= 6'h03;
    cyc(2);
    chk(gs(3), 32'h1);
    chk(gs(2), 32'h2);
    req <= 6'h00;
    cyc(1);
  endtask
  // incr4 on slave 7 ends after 4 beats; unbroken incr on slave 8 cut by slot of 3
  task t_burst;
    tgt <= 48'h171717171717;
    burst <= 3'h3;
    req <= 6'h03;
    cyc(2);
    chk(gs(7), 32'h1);
    seq <= 6'h01;
    cyc(3);
    chk(gs(7), 32'h1);
    cyc(1);
    chk(gs(7), 32'h2);
    req <= 6'h00;
    seq <= 6'h00;
    burst <= 3'h1;
    apb(1'b1, `SCFG_BASE + 12'h020, 32'h00000003);
    tgt <= 48'h181818181818;
    req <= 6'h03;
    cyc(2);
    chk(gs(8), 32'h1);
    seq <= 6'h01;
    cyc(4);
    chk(gs(8), 32'h1);
    cyc(1);
    chk(gs(8), 32'h2);
    req <= 6'h00;
    seq <= 6'h00;
    burst <= 3'h0;
  endtask
  // ==========
  // run control
  task print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    cyc(5);
    i_srst <= 1'b0;
    t_regs;
    t_rr;
    t_last;
    t_fixed;
    t_prio;
    t_remap;
    t_burst;
    print_verdict;
  end
  initial begin
    #50us;
    fail_count++;
    print_verdict;
  end
endmodule
